// [hdl/gwl_pkg.sv]
// constants for the pin port block: register map, field layout, masks
// assumes one mclk domain, synchronous active-low reset
package gwl_pkg;
	localparam int NPORT = 6;
	localparam int NPIN = 48;
	// register offsets
	localparam logic [7:0] OFF_WAKE_STS = 8'h20;
	localparam logic [7:0] OFF_WAKE_EN = 8'h28;
	localparam logic [7:0] OFF_SM_STS = 8'h30;
	localparam logic [7:0] OFF_SM_EN = 8'h38;
	localparam logic [7:0] OFF_MISC_STS = 8'h3e;
	localparam logic [7:0] OFF_WAKE_MASTER = 8'h3f;
	localparam logic [7:0] OFF_DATA = 8'h4b;
	localparam logic [7:0] OFF_LAMP_ONE = 8'h5d;
	localparam logic [7:0] OFF_LAMP_TWO = 8'h5e;
	localparam logic [7:0] OFF_CFG = 8'h60;
	// configuration fields
	localparam int CFG_DIR = 0;
	localparam int CFG_POL = 1;
	localparam int CFG_ALT = 2;
	localparam int CFG_EDGE = 3;
	localparam int CFG_TYPE = 7;
	localparam logic [7:0] CFG_RST = 8'h01;
	localparam logic [7:0] CFG_RST_P33 = 8'h00;
	localparam int PIN_P33 = 19;
	localparam int PIN_LAMP1 = 40;
	localparam int PIN_LAMP2 = 41;
	localparam logic [7:0] DATA_RST = 8'h00;
	// pins with wake and sysmgmt bits
	localparam logic [NPIN-1:0] WAKE_CAP = 48'h03_ff_0a_ff_f7_ff;
	// pins with either-edge capability
	localparam logic [NPIN-1:0] EDGE_CAP = 48'h03_00_0a_00_06_00;
	// alternates that polarity never inverts
	localparam logic [NPIN-1:0] NO_INV_ALT = 48'h00_00_08_00_00_00;
	// misc status bit positions
	localparam int MISC_PIN [6] = '{9, 10, 25, 27, 40, 41};
	// lamp modes
	localparam logic [1:0] LAMP_OFF = 2'h0;
	localparam logic [1:0] LAMP_ON = 2'h1;
	localparam logic [1:0] LAMP_SLOW = 2'h2;
	localparam logic [1:0] LAMP_FAST = 2'h3;
	localparam int BLINK_HALF_TICKS = 16384;
	typedef logic [7:0] gwl_byte_t;
endpackage : gwl_pkg

// [hdl/gwl_edge_if.sv]
// synchronised level and edge pulses passed between modules
// assumes a single mclk domain
`timescale 1ns/10ps
interface gwl_edge_if #(parameter int W = 1);
	logic [W-1:0] level;
	logic [W-1:0] rise;
	logic [W-1:0] fall;
	modport src (output level, rise, fall);
	modport dst (input level, rise, fall);
endinterface : gwl_edge_if

// [hdl/gwl_edge_sync.sv]
// two-stage synchroniser and edge detector for a group of inputs
// assumes inputs are asynchronous to mclk
`timescale 1ns/10ps
module gwl_edge_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// raw inputs
	input wire logic [W-1:0] rawIn,
	// synchronised result
	gwl_edge_if.src edgeOut
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;
	logic [W-1:0] prev_r;

	// samples through reset, so a pin resting high gives no false edge after it
	// two flops before compare
	always_ff @(posedge mclk) begin
		meta_r <= rawIn;
		sync_r <= meta_r;
		prev_r <= sync_r;
	end

	// edges from consecutive synchronised samples, none while in reset
	assign edgeOut.level = sync_r;
	assign edgeOut.rise = sync_r & ~prev_r & {W{reset_n}};
	assign edgeOut.fall = ~sync_r & prev_r & {W{reset_n}};
endmodule : gwl_edge_sync

// [hdl/gwl_lamp.sv]
// two lamp drivers with on, off and two blink rates
// assumes tick pulses once per standby clock rising edge
`timescale 1ns/10ps
module gwl_lamp
	import gwl_pkg::*;
#(
	parameter int HALF_TICKS = BLINK_HALF_TICKS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// standby clock edges
	gwl_edge_if.dst tick,
	// lamp control bytes
	input wire gwl_pkg::gwl_byte_t lampOneCtl,
	input wire gwl_pkg::gwl_byte_t lampTwoCtl,
	// lamp levels
	output logic [1:0] lampOut
);
	logic [15:0] tickCnt_r;
	logic fastPh_r;
	logic slowPh_r;

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tickCnt_r <= '0;
			fastPh_r <= 1'b0;
			slowPh_r <= 1'b0;
		end else if (tick.rise[0]) begin
			if (tickCnt_r == 16'(HALF_TICKS - 1)) begin
				tickCnt_r <= '0;
				fastPh_r <= ~fastPh_r;
				slowPh_r <= slowPh_r ^ fastPh_r;
			end else begin
				tickCnt_r <= tickCnt_r + 16'h0001;
			end
		end
	end

	function automatic logic lampLevel(input logic [1:0] mode, input logic fast,
		input logic slow);
		case (mode)
			LAMP_ON: lampLevel = 1'b1;
			LAMP_SLOW: lampLevel = slow;
			LAMP_FAST: lampLevel = fast;
			default: lampLevel = 1'b0;
		endcase
	endfunction : lampLevel

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			lampOut <= 2'h0;
		end else begin
			lampOut[0] <= lampLevel(lampOneCtl[1:0], fastPh_r, slowPh_r);
			lampOut[1] <= lampLevel(lampTwoCtl[1:0], fastPh_r, slowPh_r);
		end
	end
endmodule : gwl_lamp

// [hdl/gwl_port.sv]
// pin port: config, data, wake and sysmgmt status, either-edge, lamps
// assumes registers reached through a plain runtime register port
`timescale 1ns/10ps
module gwl_port
	import gwl_pkg::*;
#(
	parameter int BLINK_TICKS = BLINK_HALF_TICKS
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// runtime register port
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire gwl_pkg::gwl_byte_t regWrData,
	output gwl_pkg::gwl_byte_t regRdData,
	// pins
	input wire logic [gwl_pkg::NPIN-1:0] pinIn,
	output logic [gwl_pkg::NPIN-1:0] pinOut,
	output logic [gwl_pkg::NPIN-1:0] pinOe_n,
	// alternate function values
	input wire logic [gwl_pkg::NPIN-1:0] altOut,
	// power and standby clock
	input wire logic mainPowerGood,
	input wire logic standbyClk,
	// event requests
	output logic wakeEventReq,
	output logic sysmgmtReq
);
	import gwl_pkg::*;

	gwl_byte_t cfg_r [NPIN];
	gwl_byte_t data_r [NPORT];
	gwl_byte_t wakeSts_r [NPORT];
	gwl_byte_t wakeEn_r [NPORT];
	gwl_byte_t smSts_r [NPORT];
	gwl_byte_t smEn_r [NPORT];
	logic [5:0] miscSts_r;
	logic wakeMaster_r;
	gwl_byte_t lampOne_r;
	gwl_byte_t lampTwo_r;
	logic [1:0] lampOut;
	logic [NPIN-1:0] pinLevel;
	logic [NPIN-1:0] pinRise;
	logic [NPIN-1:0] pinFall;
	logic [NPIN-1:0] dirIn;
	logic [NPIN-1:0] pol;
	logic [NPIN-1:0] edgeOn;
	logic [NPIN-1:0] wakeHit;
	logic [NPIN-1:0] anyEdge;
	logic [NPIN-1:0] outVal;
	logic [NPIN-1:0] drive;
	logic [NPIN-1:0] irqGate;
	logic [NPIN-1:0] wakeStsF;
	logic [NPIN-1:0] wakeEnF;
	logic [NPIN-1:0] smStsF;
	logic [NPIN-1:0] smEnF;

	////////////////////////////////////////////////////////////////////
	// synchronisers

	gwl_edge_if #(.W(NPIN)) pinEdge ();
	gwl_edge_if #(.W(1)) clkEdge ();

	gwl_edge_sync #(.W(NPIN)) uPinSync (
		.mclk(mclk),
		.reset_n(reset_n),
		.rawIn(pinIn),
		.edgeOut(pinEdge.src)
	);

	gwl_edge_sync #(.W(1)) uClkSync (
		.mclk(mclk),
		.reset_n(reset_n),
		.rawIn(standbyClk),
		.edgeOut(clkEdge.src)
	);

	gwl_lamp #(.HALF_TICKS(BLINK_TICKS)) uLamp (
		.mclk(mclk),
		.reset_n(reset_n),
		.tick(clkEdge.dst),
		.lampOneCtl(lampOne_r),
		.lampTwoCtl(lampTwo_r),
		.lampOut(lampOut)
	);

	assign pinLevel = pinEdge.level;
	assign pinRise = pinEdge.rise;
	assign pinFall = pinEdge.fall;

	////////////////////////////////////////////////////////////////////
	// address helpers

	// true when addr falls in a block of n registers from base
	function automatic logic inBlock(input logic [7:0] addr, input logic [7:0] base,
		input int n);
		inBlock = (addr >= base) && (int'(addr) < int'(base) + n);
	endfunction : inBlock

	function automatic int blockIdx(input logic [7:0] addr, input logic [7:0] base);
		blockIdx = int'(addr - base);
	endfunction : blockIdx

	function automatic logic wrHit(input logic [7:0] base, input int idx);
		wrHit = regWrEn && (regAddr == 8'(int'(base) + idx));
	endfunction : wrHit

	////////////////////////////////////////////////////////////////////
	// per-pin effective configuration

	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			edgeOn[i] = EDGE_CAP[i] & cfg_r[i][CFG_EDGE];
			dirIn[i] = cfg_r[i][CFG_DIR];
			pol[i] = cfg_r[i][CFG_POL];
			if (i == PIN_P33 && !mainPowerGood) begin
				dirIn[i] = 1'b0;
				pol[i] = 1'b0;
			end
			if (edgeOn[i]) begin
				dirIn[i] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// edge events and interrupt gating

	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			anyEdge[i] = pinRise[i] | pinFall[i];
			wakeHit[i] = pol[i] ? pinFall[i] : pinRise[i];
			if (edgeOn[i]) begin
				wakeHit[i] = anyEdge[i];
			end
			wakeHit[i] = wakeHit[i] & WAKE_CAP[i];
			irqGate[i] = ~EDGE_CAP[i] | cfg_r[i][CFG_EDGE];
		end
	end

	// flat views of the status and enable bytes
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			wakeStsF[p*8 +: 8] = wakeSts_r[p];
			wakeEnF[p*8 +: 8] = wakeEn_r[p];
			smStsF[p*8 +: 8] = smSts_r[p];
			smEnF[p*8 +: 8] = smEn_r[p];
		end
	end

	// status and enable set, the either-edge select too on capable pins, and for the wake request the master too
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			wakeEventReq <= 1'b0;
			sysmgmtReq <= 1'b0;
		end else begin
			wakeEventReq <= wakeMaster_r & |(wakeStsF & wakeEnF & irqGate & WAKE_CAP);
			sysmgmtReq <= |(smStsF & smEnF & irqGate & WAKE_CAP);
		end
	end

	////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			for (int i = 0; i < NPIN; i++) begin
				cfg_r[i] <= (i == PIN_P33) ? CFG_RST_P33 : CFG_RST;
			end
		end else begin
			for (int i = 0; i < NPIN; i++) begin
				if (wrHit(OFF_CFG, i)) begin
					cfg_r[i] <= regWrData;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// data registers

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			for (int p = 0; p < NPORT; p++) begin
				data_r[p] <= DATA_RST;
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				if (wrHit(OFF_DATA, p)) begin
					for (int b = 0; b < 8; b++) begin
						if (!dirIn[p*8+b]) begin
							data_r[p][b] <= regWrData[b];
						end
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// wake and sysmgmt status, set wins over clear

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			for (int p = 0; p < NPORT; p++) begin
				wakeSts_r[p] <= '0;
				smSts_r[p] <= '0;
			end
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				wakeSts_r[p] <= (wakeSts_r[p] & ~(wrHit(OFF_WAKE_STS, p) ? regWrData : 8'h00))
					| wakeHit[p*8 +: 8];
				smSts_r[p] <= (smSts_r[p] & ~(wrHit(OFF_SM_STS, p) ? regWrData : 8'h00))
					| wakeHit[p*8 +: 8];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			miscSts_r <= 6'h00;
		end else begin
			for (int k = 0; k < 6; k++) begin
				miscSts_r[k] <= (miscSts_r[k]
					& ~(regWrEn && regAddr == OFF_MISC_STS && regWrData[k]))
					| anyEdge[MISC_PIN[k]];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// enables and lamp control

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			for (int p = 0; p < NPORT; p++) begin
				wakeEn_r[p] <= '0;
				smEn_r[p] <= '0;
			end
			wakeMaster_r <= 1'b0;
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				if (wrHit(OFF_WAKE_EN, p)) begin
					wakeEn_r[p] <= regWrData & WAKE_CAP[p*8 +: 8];
				end
				if (wrHit(OFF_SM_EN, p)) begin
					smEn_r[p] <= regWrData & WAKE_CAP[p*8 +: 8];
				end
			end
			if (regWrEn && regAddr == OFF_WAKE_MASTER) begin
				wakeMaster_r <= regWrData[0];
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			lampOne_r <= '0;
			lampTwo_r <= '0;
		end else if (regWrEn) begin
			if (regAddr == OFF_LAMP_ONE) begin
				lampOne_r <= regWrData;
			end else if (regAddr == OFF_LAMP_TWO) begin
				lampTwo_r <= regWrData;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// register reads, latched at the read strobe

	function automatic gwl_byte_t dataView(input int p);
		dataView = '0;
		for (int b = 0; b < 8; b++) begin
			dataView[b] = dirIn[p*8+b] ? (pinLevel[p*8+b] ^ pol[p*8+b]) : data_r[p][b];
		end
	endfunction : dataView

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			regRdData <= '0;
		end else if (regRdEn) begin
			if (inBlock(regAddr, OFF_CFG, NPIN)) begin
				regRdData <= cfg_r[blockIdx(regAddr, OFF_CFG)];
			end else if (inBlock(regAddr, OFF_DATA, NPORT)) begin
				regRdData <= dataView(blockIdx(regAddr, OFF_DATA));
			end else if (inBlock(regAddr, OFF_WAKE_STS, NPORT)) begin
				regRdData <= wakeSts_r[blockIdx(regAddr, OFF_WAKE_STS)];
			end else if (inBlock(regAddr, OFF_WAKE_EN, NPORT)) begin
				regRdData <= wakeEn_r[blockIdx(regAddr, OFF_WAKE_EN)];
			end else if (inBlock(regAddr, OFF_SM_STS, NPORT)) begin
				regRdData <= smSts_r[blockIdx(regAddr, OFF_SM_STS)];
			end else if (inBlock(regAddr, OFF_SM_EN, NPORT)) begin
				regRdData <= smEn_r[blockIdx(regAddr, OFF_SM_EN)];
			end else if (regAddr == OFF_MISC_STS) begin
				regRdData <= {2'h0, miscSts_r};
			end else if (regAddr == OFF_WAKE_MASTER) begin
				regRdData <= {7'h00, wakeMaster_r};
			end else if (regAddr == OFF_LAMP_ONE) begin
				regRdData <= lampOne_r;
			end else if (regAddr == OFF_LAMP_TWO) begin
				regRdData <= lampTwo_r;
			end else begin
				regRdData <= 8'h00;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin drivers

	always_comb begin
		for (int i = 0; i < NPIN; i++) begin
			outVal[i] = data_r[i/8][i%8] ^ pol[i];
			if (cfg_r[i][CFG_ALT] && !(i == PIN_P33 && !mainPowerGood)) begin
				outVal[i] = altOut[i] ^ (pol[i] & ~NO_INV_ALT[i]);
				if (i == PIN_LAMP1) begin
					outVal[i] = lampOut[0] ^ pol[i];
				end else if (i == PIN_LAMP2) begin
					outVal[i] = lampOut[1] ^ pol[i];
				end
			end
			drive[i] = ~dirIn[i] & (~cfg_r[i][CFG_TYPE] | ~outVal[i]);
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pinOut <= '0;
			pinOe_n <= ~(~CFG_RST[CFG_DIR] ? {NPIN{1'b1}} : ({{(NPIN-1){1'b0}}, 1'b1} << PIN_P33));
		end else begin
			pinOut <= outVal;
			pinOe_n <= ~drive;
		end
	end
endmodule : gwl_port

// [testbench/gwl_port_monitor.sv]
// checker for gwl_port, bound to its top-level ports
// assumes one mclk domain with a synchronous active-low reset
`timescale 1ns/10ps
module gwl_port_monitor
	import gwl_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire gwl_pkg::gwl_byte_t regWrData,
	input wire gwl_pkg::gwl_byte_t regRdData,
	// pins and requests
	input wire logic [gwl_pkg::NPIN-1:0] pinOut,
	input wire logic [gwl_pkg::NPIN-1:0] pinOe_n,
	input wire logic standbyClk,
	input wire logic wakeEventReq,
	input wire logic sysmgmtReq
);
	logic masterOn_r;
	logic stbyOld_r;
	logic [3:0] quiet_r;
	logic [NPIN-1:0] od_r;
	logic [1:0] wrLate_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////
	// shadow of the wake master enable
	always_ff @(posedge mclk) begin
		if (!reset_n)
			masterOn_r <= 1'b0;
		else if (regWrEn && regAddr == OFF_WAKE_MASTER)
			masterOn_r <= regWrData[0];
	end
	// shadow of every open-drain select bit
	always_ff @(posedge mclk) begin
		if (!reset_n)
			od_r <= '0;
		else if (regWrEn && regAddr >= OFF_CFG && regAddr < OFF_CFG + 8'h30)
			od_r[regAddr - OFF_CFG] <= regWrData[CFG_TYPE];
	end
	// cycles since the standby clock last moved
	always_ff @(posedge mclk) begin
		stbyOld_r <= standbyClk;
		if (!reset_n || standbyClk != stbyOld_r)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hf)
			quiet_r <= quiet_r + 4'h1;
	end
	// write strobes of the two cycles before, which still reach the pins
	always_ff @(posedge mclk) begin
		if (!reset_n)
			wrLate_r <= 2'h0;
		else
			wrLate_r <= {wrLate_r[0], regWrEn};
	end
	////////////////////////////////////////
	// pin levels after reset
	property p_rst_pins;
		$rose(reset_n) |-> pinOe_n == 48'hffff_fff7_ffff && pinOut == '0;
	endproperty
	a_rst_pins: assert property (p_rst_pins) else $error("pins wrong after reset");
	property p_unl;
		regRdEn && regAddr inside {8'h21, 8'h29, 8'h31, 8'h39} |=> !regRdData[3];
	endproperty
	a_unl: assert property (p_unl) else $error("unlisted port2 bit set");
	property p_p4;
		regRdEn && regAddr inside {8'h23, 8'h2b, 8'h33, 8'h3b} |=> (regRdData & 8'hf5) == 8'h00;
	endproperty
	a_p4: assert property (p_p4) else $error("unlisted port4 bit set");
	property p_misc;
		regRdEn && regAddr == OFF_MISC_STS |=> regRdData[7:6] == 2'h0;
	endproperty
	a_misc: assert property (p_misc) else $error("misc spare bit set");
	property p_hold;
		!regRdEn |=> $stable(regRdData);
	endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_master;
		!masterOn_r |=> !wakeEventReq;
	endproperty
	a_master: assert property (p_master) else $error("wake without master");
	property p_od;
		(~pinOe_n & pinOut & od_r & $past(od_r)) == '0;
	endproperty
	a_od: assert property (p_od) else $error("open drain drove high");
	property p_lamp;
		quiet_r > 4'h8 && !regWrEn && wrLate_r == 2'h0 |=> $stable(pinOut[41:40]);
	endproperty
	a_lamp: assert property (p_lamp) else $error("lamp moved without ticks");
	// main scenarios reached
	c_wake: cover property ($rose(wakeEventReq));
	c_sm: cover property ($rose(sysmgmtReq));
	c_blink: cover property ($changed(pinOut[41]));
endmodule : gwl_port_monitor
bind gwl_port gwl_port_monitor i_gwl_port_monitor (.mclk, .reset_n, .regAddr, .regWrEn,
	.regRdEn, .regWrData, .regRdData, .pinOut, .pinOe_n, .standbyClk, .wakeEventReq,
	.sysmgmtReq);

// [testbench/gwl_pin_model.sv]
// far side of the pins: external levels and the standby clock
// assumes pinOe_n low means the port drives the pin
`timescale 1ns/10ps
module gwl_pin_model (
	// port side
	input wire logic [47:0] pinOut,
	input wire logic [47:0] pinOe_n,
	output logic [47:0] pinIn,
	// bench side
	input wire logic [47:0] extLevel,
	input wire logic standbyRun,
	output logic standbyClk
);
	// released pins show the external level, driven pins the port's own value
	assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & extLevel);
	// standby clock, held still when stopped
	initial begin
		standbyClk = 1'b0;
		#3;
		forever begin
			#65;
			if (standbyRun)
				standbyClk = ~standbyClk;
		end
	end
endmodule : gwl_pin_model

// [testbench/tb_gwl_port.sv]
// testbench for gwl_port: register tasks, pin model, checks
// assumes the checker binds itself from its own file
`timescale 1ns/10ps
module tb_gwl_port;
	import gwl_pkg::*;
	logic mclk, reset_n, regWrEn, regRdEn, mainPowerGood, standbyRun, standbyClk, v;
	logic wakeEventReq, sysmgmtReq;
	logic [7:0] regAddr;
	gwl_byte_t regWrData, regRdData, rv;
	logic [NPIN-1:0] pinIn, pinOut, pinOe_n, altOut, extLevel;
	gwl_byte_t msk [3] = '{8'hf7, 8'h0a, 8'h03};
	int badCount = 0;
	int nTests = 0;
	int cnt;
	gwl_port #(.BLINK_TICKS(4)) i_gwl_port (.mclk, .reset_n, .regAddr, .regWrEn, .regRdEn,
		.regWrData, .regRdData, .pinIn, .pinOut, .pinOe_n, .altOut, .mainPowerGood,
		.standbyClk, .wakeEventReq, .sysmgmtReq);
	gwl_pin_model i_gwl_pin_model (.pinOut, .pinOe_n, .pinIn, .extLevel, .standbyRun,
		.standbyClk);
	////////////////////////////////////////
	// compare and count
	task automatic chk(input string w, input gwl_byte_t seen, input gwl_byte_t e);
		nTests++;
		if (seen !== e) begin
			badCount++;
			$display("wrong value %s expected %h seen %h", w, e, seen);
		end
	endtask : chk
	task automatic end_of_test;
		if (badCount == 0 && nTests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	// bus cycles, one strobe cycle each
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input gwl_byte_t d);
		cyc(1);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		cyc(1);
		regWrEn = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output gwl_byte_t d);
		cyc(1);
		regAddr = a;
		regRdEn = 1'b1;
		cyc(1);
		regRdEn = 1'b0;
		d = regRdData;
	endtask : rd
	task automatic rdc(input string w, input logic [7:0] a, input gwl_byte_t e);
		rd(a, rv);
		chk(w, rv, e);
	endtask : rdc
	// pin check as {enable_n, value}
	task automatic pin(input string w, input int i, input logic [1:0] e);
		cyc(2);
		chk(w, {6'h0, pinOe_n[i], pinOut[i]}, {6'h0, e});
	endtask : pin
	// clear every status bit
	task automatic clr;
		for (int i = 0; i < 6; i++) begin
			wr(OFF_WAKE_STS + 8'(i), 8'hff);
			wr(OFF_SM_STS + 8'(i), 8'hff);
		end
		wr(OFF_MISC_STS, 8'hff);
	endtask : clr
	// cycles between two lamp-two toggles, bounded
	task automatic gap(output int n);
		v = pinOut[41];
		n = 0;
		while (pinOut[41] === v) begin
			cyc(1);
			n++;
			if (n > 300) begin
				chk("blink wait", 8'h01, 8'h00);
				end_of_test();
			end
		end
	endtask : gap
	////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// main sequence
	initial begin
		reset_n = 1'b0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		altOut = '0;
		mainPowerGood = 1'b1;
		standbyRun = 1'b0;
		extLevel = 48'h0000_0000_005a;
		repeat (8) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		// reset state
		pin("p33 rst", 19, 2'b00);
		pin("p43 rst", 27, 2'b10);
		rdc("cfg0", OFF_CFG, CFG_RST);
		rdc("cfg19", OFF_CFG + 8'h13, CFG_RST_P33);
		// input reads, ignored writes
		rdc("in", OFF_DATA, 8'h5a);
		wr(OFF_CFG, 8'h03);
		rdc("in inv", OFF_DATA, 8'h5b);
		wr(OFF_DATA, 8'hff);
		wr(OFF_CFG + 8'h02, 8'h00);
		pin("in wr", 2, 2'b00);
		// outputs, inverted and open drain
		wr(OFF_CFG + 8'h01, 8'h02);
		wr(OFF_DATA, 8'h02);
		pin("out inv", 1, 2'b00);
		rdc("out rd", OFF_DATA, 8'h5b);
		wr(OFF_CFG + 8'h01, 8'h82);
		pin("od low", 1, 2'b00);
		wr(OFF_DATA, 8'h00);
		pin("od off", 1, 2'b11);
		// alternate polarity, density pin excepted
		altOut[8] = 1'b1;
		altOut[27] = 1'b1;
		wr(OFF_CFG + 8'h08, 8'h06);
		pin("alt inv", 8, 2'b00);
		wr(OFF_CFG + 8'h1b, 8'h06);
		pin("alt dens", 27, 2'b01);
		// wake on rising edge, master gate, write-one clear
		clr();
		wr(OFF_WAKE_EN, 8'h20);
		extLevel[5] = 1'b1;
		cyc(5);
		rdc("wake sts", OFF_WAKE_STS, 8'h20);
		rdc("sm sts", OFF_SM_STS, 8'h20);
		chk("wake off", 8'(wakeEventReq), 8'h00);
		wr(OFF_WAKE_MASTER, 8'h01);
		cyc(2);
		chk("wake on", 8'(wakeEventReq), 8'h01);
		rdc("master", OFF_WAKE_MASTER, 8'h01);
		wr(OFF_WAKE_STS, 8'h00);
		rdc("wr zero", OFF_WAKE_STS, 8'h20);
		wr(OFF_WAKE_STS, 8'h20);
		extLevel[5] = 1'b0;
		cyc(5);
		rdc("fall", OFF_WAKE_STS, 8'h00);
		// either-edge pins
		// port2 bit1 sysmgmt enable set
		wr(8'h39, 8'h02);
		rdc("sm en", 8'h39, 8'h02);
		for (int k = 0; k < 6; k++) begin
			wr(OFF_CFG + 8'(MISC_PIN[k]), 8'h09);
			cyc(4);
			wr(OFF_MISC_STS, 8'hff);
			extLevel[MISC_PIN[k]] = ~extLevel[MISC_PIN[k]];
			cyc(5);
			rdc("misc", OFF_MISC_STS, 8'(1 << k));
		end
		clr();
		extLevel[9] = 1'b0;
		cyc(5);
		rdc("ee fall", 8'h31, 8'h02);
		chk("ee req", 8'(sysmgmtReq), 8'h01);
		wr(OFF_CFG + 8'h09, 8'h0b);
		rd(8'h4c, rv);
		chk("ee pol", 8'(rv[1]), 8'h01);
		wr(OFF_CFG + 8'h09, 8'h01);
		clr();
		extLevel[9] = 1'b1;
		cyc(5);
		rdc("no mode", 8'h31, 8'h02);
		rdc("misc any", OFF_MISC_STS, 8'h01);
		chk("no req", 8'(sysmgmtReq), 8'h00);
		// lamps: steady, inverted, blink, stopped clock
		wr(OFF_CFG + 8'h28, 8'h04);
		wr(OFF_LAMP_ONE, 8'h01);
		pin("lamp on", 40, 2'b01);
		wr(OFF_CFG + 8'h28, 8'h06);
		pin("lamp inv", 40, 2'b00);
		rdc("lamp rd", OFF_LAMP_ONE, 8'h01);
		wr(OFF_CFG + 8'h29, 8'h04);
		standbyRun = 1'b1;
		for (int m = 2; m < 4; m++) begin
			wr(OFF_LAMP_TWO, 8'(m));
			gap(cnt);
			gap(cnt);
			chk("blink", 8'(cnt), (m == 3) ? 8'h34 : 8'h68);
		end
		standbyRun = 1'b0;
		cyc(10);
		v = pinOut[41];
		cnt = 0;
		repeat (300) begin
			cyc(1);
			cnt += (pinOut[41] !== v) ? 1 : 0;
		end
		chk("no clock", 8'(cnt), 8'h00);
		// supply loss forces a plain output
		wr(OFF_CFG + 8'h13, 8'h03);
		mainPowerGood = 1'b0;
		pin("p33 off", 19, 2'b00);
		mainPowerGood = 1'b1;
		// unmapped and unlisted places
		rdc("unmapped", 8'h00, 8'h00);
		for (int j = 0; j < 3; j++) begin
			wr(8'h29 + 8'(2 * j), 8'hff);
			rdc("unlisted", 8'h29 + 8'(2 * j), msk[j]);
		end
		end_of_test();
	end
endmodule : tb_gwl_port
